// ### pkg/dra_defines.vh
// constants for the debug register access block
// Notes on behaviour
// R1: unit one unmasked: full 24-bit match breaks
// R2: unit one masked: bits 23:8 match breaks
// R3: unit zero unmasked: full 24-bit match breaks
// R4: unit zero masked: bits 23:8, enable required
// R5: single step breaks after every instruction
// R6: master bit 7 resets, self-clears after
// R7: master control write wakes from halt/sleep
// R8: three staged write-data bytes at 13h-15h
// R9: short writes use least significant bytes
// R10: command at 16h follows data bytes
// R11: command write executes operation immediately
// R12: reads fill read bytes, writes use staged
// R13: codes 00-07/80-87 move register groups
// R14: 06/86 stack pointer; 08/09 set/clear mode
// R15: code 0A exchanges main and alternate sets
// R16: 0B/8B memory at pc, then increment
// R17: host exchanges sets before reading alternates
// R18: master control resets zero, bits 6:0 reserved
// R19: match sets break flag until host clears
// R20: breaks only at instruction boundaries; code breaks at once on a 10h write with bit 7 set
// R21: units break only when own enable set
// R22: unlisted command codes do nothing
// R23: commands act only during debug break
`ifndef DRA_DEFINES_VH
`define DRA_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets on the debug link
`define DRA_OFS_M0_LOW 7'h00
`define DRA_OFS_M0_HIGH 7'h01
`define DRA_OFS_M0_UPPER 7'h02
`define DRA_OFS_M1_LOW 7'h04
`define DRA_OFS_M1_HIGH 7'h05
`define DRA_OFS_M1_UPPER 7'h06
`define DRA_OFS_BRK_CTL 7'h10
`define DRA_OFS_MASTER 7'h11
`define DRA_OFS_WR_UPPER 7'h13
`define DRA_OFS_WR_HIGH 7'h14
`define DRA_OFS_WR_LOW 7'h15
`define DRA_OFS_COMMAND 7'h16

////////////////////////////////////////////////////////////////////////////////
// field positions
`define DRA_BRK_NEXT_BIT 7
`define DRA_BRK_EN1_BIT 4
`define DRA_BRK_EN0_BIT 3
`define DRA_BRK_IGN1_BIT 2
`define DRA_BRK_IGN0_BIT 1
`define DRA_BRK_STEP_BIT 0
`define DRA_MASTER_RESET_BIT 7

////////////////////////////////////////////////////////////////////////////////
// reset values
`define DRA_BRK_CTL_RST 8'h00
`define DRA_MASTER_RST 8'h00

////////////////////////////////////////////////////////////////////////////////
// command codes
`define DRA_CMD_RD_AF 8'h00
`define DRA_CMD_RD_PC 8'h07
`define DRA_CMD_SP_READ 8'h06
`define DRA_CMD_SET_ADL 8'h08
`define DRA_CMD_CLR_ADL 8'h09
`define DRA_CMD_EXCH 8'h0A
`define DRA_CMD_RD_MEM 8'h0B
`define DRA_CMD_WR_AF 8'h80
`define DRA_CMD_WR_PC 8'h87
`define DRA_CMD_WR_MEM 8'h8B

////////////////////////////////////////////////////////////////////////////////
// link framing
`define DRA_LINK_BITS 3'h7

`endif

// ### rtl/dra_sync.v
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module dra_sync #(
   parameter W = 2
) (
   // clock and reset
   input wire clk_i,
   input wire rstn_i,
   // asynchronous in, synchronous out
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   genvar gi;
   generate
      for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
         reg meta_ff;
         reg sync_ff;
         always @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               meta_ff <= 1'b1;
               sync_ff <= 1'b1;
            end else begin
               meta_ff <= async_i[gi];
               sync_ff <= meta_ff;
            end
         end
         assign sync_o[gi] = sync_ff;
      end
   endgenerate

endmodule // dra_sync

`default_nettype wire

// ### rtl/dra_match.v
// one instruction address match unit
`timescale 1ns/1ps
`default_nettype none

module dra_match (
   // compare inputs
   input wire [23:0] addr_i,
   input wire [23:0] match_i,
   input wire enable_i,
   input wire ign_low_i,
   // result
   output wire hit_o
);

   wire upper_eq;
   wire low_eq;

   assign upper_eq = (addr_i[23:8] == match_i[23:8]);
   assign low_eq = (addr_i[7:0] == match_i[7:0]);
   // masked unit ignores low byte, any unit needs its enable
   assign hit_o = enable_i & upper_eq & (ign_low_i | low_eq); // see R1 see R2 see R3 see R4 see R21

endmodule // dra_match

`default_nettype wire

// ### rtl/dra_top.v
// debug register access: serial write link, break logic, command engine
`timescale 1ns/1ps
`default_nettype none
`include "dra_defines.vh"

module dra_top (
   // clock and reset
   input wire clk_i,
   input wire rstn_i,
   // serial debug link pins
   input wire dbg_clk_i,
   input wire dbg_data_i,
   // cpu instruction flow
   input wire [23:0] instr_addr_i,
   input wire fetch_i,
   input wire instr_end_i,
   // cpu command handshake
   input wire cmd_done_i,
   input wire [23:0] rd_value_i,
   output reg cmd_valid_o,
   output reg [7:0] cmd_code_o,
   output reg [23:0] cmd_data_o,
   // cpu control
   output reg cpu_break_o,
   output reg dev_reset_o,
   input wire reset_done_i,
   output reg wake_o,
   // read data bytes
   output reg [7:0] rd_upper_o,
   output reg [7:0] rd_high_o,
   output reg [7:0] rd_low_o
);

   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_ADDR = 5'h02;
   localparam [4:0] ST_SEP = 5'h04;
   localparam [4:0] ST_DATA = 5'h08;
   localparam [4:0] ST_SKIP = 5'h10;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisation and edge detection
   wire [1:0] pins_s;
   reg lclk_q_ff;
   reg ldat_q_ff;
   wire lclk_s;
   wire ldat_s;
   wire lclk_rise;
   wire frame_start;
   wire frame_stop;

   dra_sync #(.W(2)) u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .async_i({dbg_clk_i, dbg_data_i}),
      .sync_o(pins_s)
   );

   assign lclk_s = pins_s[1];
   assign ldat_s = pins_s[0];

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lclk_q_ff <= 1'b1;
         ldat_q_ff <= 1'b1;
      end else begin
         lclk_q_ff <= lclk_s;
         ldat_q_ff <= ldat_s;
      end
   end

   assign lclk_rise = lclk_s & ~lclk_q_ff;
   assign frame_start = lclk_s & lclk_q_ff & ldat_q_ff & ~ldat_s;
   assign frame_stop = lclk_s & lclk_q_ff & ~ldat_q_ff & ldat_s;

   ////////////////////////////////////////////////////////////////////////////////
   // link framing: address, direction, then auto-incremented bytes
   reg [4:0] state_ff;
   reg [4:0] nxt_state;
   reg [2:0] bit_cnt_ff;
   reg [2:0] nxt_bit_cnt;
   reg [7:0] shift_ff;
   reg [7:0] nxt_shift;
   reg [6:0] addr_ff;
   reg [6:0] nxt_addr;
   reg wr_en_ff;
   reg nxt_wr_en;
   reg [6:0] wr_addr_ff;
   reg [7:0] wr_byte_ff;
   wire [7:0] shifted;

   assign shifted = {shift_ff[6:0], ldat_s};

   always @* begin
      nxt_state = state_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_shift = shift_ff;
      nxt_addr = addr_ff;
      nxt_wr_en = 1'b0;
      if (frame_stop) begin
         nxt_state = ST_IDLE;
      end else if (frame_start) begin
         nxt_state = ST_ADDR;
         nxt_bit_cnt = 3'h0;
      end else if (lclk_rise) begin
         case (state_ff)
            ST_ADDR: begin
               nxt_shift = shifted;
               nxt_bit_cnt = bit_cnt_ff + 3'h1;
               if (bit_cnt_ff == `DRA_LINK_BITS) begin
                  nxt_addr = shifted[7:1];
                  nxt_state = shifted[0] ? ST_SKIP : ST_SEP;
               end
            end
            ST_SEP: begin
               nxt_state = ST_DATA;
               nxt_bit_cnt = 3'h0;
            end
            ST_DATA: begin
               nxt_shift = shifted;
               nxt_bit_cnt = bit_cnt_ff + 3'h1;
               if (bit_cnt_ff == `DRA_LINK_BITS) begin
                  nxt_wr_en = 1'b1;
                  nxt_addr = addr_ff + 7'h01; // see R10
                  nxt_state = ST_SEP;
               end
            end
            ST_IDLE: begin
               nxt_state = ST_IDLE;
            end
            ST_SKIP: begin
               nxt_state = ST_SKIP;
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 3'h0;
         shift_ff <= 8'h00;
         addr_ff <= 7'h00;
         wr_en_ff <= 1'b0;
         wr_addr_ff <= 7'h00;
         wr_byte_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff <= nxt_shift;
         addr_ff <= nxt_addr;
         wr_en_ff <= nxt_wr_en;
         if (nxt_wr_en) begin
            wr_addr_ff <= addr_ff;
            wr_byte_ff <= shifted;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write-only register file
   reg [23:0] match0_ff;
   reg [23:0] match1_ff;
   reg [6:0] brk_ctl_ff;
   localparam [7:0] BRK_RST = `DRA_BRK_CTL_RST;
   reg [23:0] wr_data_ff;
   wire hit0;
   wire hit1;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         match0_ff <= 24'h000000;
         match1_ff <= 24'h000000;
         brk_ctl_ff <= BRK_RST[6:0];
         wr_data_ff <= 24'h000000;
      end else if (wr_en_ff) begin
         case (wr_addr_ff)
            `DRA_OFS_M0_LOW: match0_ff[7:0] <= wr_byte_ff;
            `DRA_OFS_M0_HIGH: match0_ff[15:8] <= wr_byte_ff;
            `DRA_OFS_M0_UPPER: match0_ff[23:16] <= wr_byte_ff;
            `DRA_OFS_M1_LOW: match1_ff[7:0] <= wr_byte_ff;
            `DRA_OFS_M1_HIGH: match1_ff[15:8] <= wr_byte_ff;
            `DRA_OFS_M1_UPPER: match1_ff[23:16] <= wr_byte_ff;
            `DRA_OFS_BRK_CTL: brk_ctl_ff <= wr_byte_ff[6:0];
            `DRA_OFS_WR_UPPER: wr_data_ff[23:16] <= wr_byte_ff; // see R8
            `DRA_OFS_WR_HIGH: wr_data_ff[15:8] <= wr_byte_ff; // see R8
            `DRA_OFS_WR_LOW: wr_data_ff[7:0] <= wr_byte_ff; // see R8
            default: begin
               match0_ff <= match0_ff;
            end
         endcase
      end
   end

   dra_match u_match0 (
      .addr_i(instr_addr_i),
      .match_i(match0_ff),
      .enable_i(brk_ctl_ff[`DRA_BRK_EN0_BIT]),
      .ign_low_i(brk_ctl_ff[`DRA_BRK_IGN0_BIT]),
      .hit_o(hit0)
   );

   dra_match u_match1 (
      .addr_i(instr_addr_i),
      .match_i(match1_ff),
      .enable_i(brk_ctl_ff[`DRA_BRK_EN1_BIT]),
      .ign_low_i(brk_ctl_ff[`DRA_BRK_IGN1_BIT]),
      .hit_o(hit1)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // break flag: pending match taken at instruction end
   reg pend_ff;
   wire brk_write;
   wire brk_event;

   assign brk_write = wr_en_ff & (wr_addr_ff == `DRA_OFS_BRK_CTL);
   assign brk_event = instr_end_i & ~cpu_break_o
      & (pend_ff | (fetch_i & (hit0 | hit1)) | brk_ctl_ff[`DRA_BRK_STEP_BIT]); // see R5 see R20

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_ff <= 1'b0;
         cpu_break_o <= 1'b0;
      end else begin
         if (instr_end_i) begin
            pend_ff <= 1'b0;
         end else if (fetch_i & (hit0 | hit1)) begin
            pend_ff <= 1'b1; // see R20
         end
         if (brk_event) begin
            cpu_break_o <= 1'b1; // see R19
         end else if (brk_write) begin
            cpu_break_o <= wr_byte_ff[`DRA_BRK_NEXT_BIT]; // see R19
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // master control: reset request and wake
   wire mst_write;
   localparam [7:0] MST_RST = `DRA_MASTER_RST;

   assign mst_write = wr_en_ff & (wr_addr_ff == `DRA_OFS_MASTER);

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dev_reset_o <= MST_RST[`DRA_MASTER_RESET_BIT]; // see R18
         wake_o <= 1'b0;
      end else begin
         wake_o <= mst_write; // see R7
         if (mst_write & wr_byte_ff[`DRA_MASTER_RESET_BIT]) begin
            dev_reset_o <= 1'b1; // see R6
         end else if (reset_done_i) begin
            dev_reset_o <= 1'b0; // see R6
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // command engine
   reg code_ok;
   reg is_read;
   wire cmd_write;
   wire [7:0] code_in;

   assign cmd_write = wr_en_ff & (wr_addr_ff == `DRA_OFS_COMMAND);
   assign code_in = wr_byte_ff;

   always @* begin
      code_ok = 1'b0;
      is_read = 1'b0;
      if (code_in <= `DRA_CMD_RD_MEM) begin
         code_ok = 1'b1; // see R13 see R14 see R15 see R16
         is_read = (code_in <= `DRA_CMD_RD_PC) | (code_in == `DRA_CMD_RD_MEM);
      end else if ((code_in >= `DRA_CMD_WR_AF) & (code_in <= `DRA_CMD_WR_PC)) begin
         code_ok = 1'b1; // see R13 see R14
      end else if (code_in == `DRA_CMD_WR_MEM) begin
         code_ok = 1'b1; // see R16
      end
   end

   reg rd_pend_ff;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmd_valid_o <= 1'b0;
         cmd_code_o <= 8'h00;
         cmd_data_o <= 24'h000000;
         rd_pend_ff <= 1'b0;
         rd_upper_o <= 8'h00;
         rd_high_o <= 8'h00;
         rd_low_o <= 8'h00;
      end else begin
         if (cmd_valid_o) begin
            if (cmd_done_i) begin
               cmd_valid_o <= 1'b0;
               if (rd_pend_ff) begin
                  rd_low_o <= rd_value_i[7:0]; // see R12
                  if (cmd_code_o != `DRA_CMD_RD_MEM) begin
                     rd_upper_o <= rd_value_i[23:16]; // see R12
                     rd_high_o <= rd_value_i[15:8]; // see R12
                  end
               end
            end
         end else if (cmd_write & code_ok & cpu_break_o) begin
            cmd_valid_o <= 1'b1; // see R11 see R22 see R23
            cmd_code_o <= code_in;
            rd_pend_ff <= is_read;
            if (code_in == `DRA_CMD_WR_MEM) begin
               cmd_data_o <= {16'h0000, wr_data_ff[7:0]}; // see R9
            end else begin
               cmd_data_o <= wr_data_ff; // see R12
            end
         end
      end
   end

endmodule // dra_top

`default_nettype wire

// ### verif/dra_props.sv
// assertion checker for the debug register access block
`timescale 1ns/1ps
`default_nettype none
module dra_props (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // cpu side
   input wire logic cmd_done_i,
   input wire logic [23:0] rd_value_i,
   input wire logic reset_done_i,
   input wire logic cmd_valid_o,
   input wire logic [7:0] cmd_code_o,
   input wire logic [23:0] cmd_data_o,
   input wire logic cpu_break_o,
   input wire logic dev_reset_o,
   input wire logic wake_o,
   // read data bytes
   input wire logic [7:0] rd_upper_o,
   input wire logic [7:0] rd_high_o,
   input wire logic [7:0] rd_low_o
);
   wire logic [7:0] rv_low = rd_value_i[7:0];
   wire logic done = cmd_valid_o && cmd_done_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   chk_valid_hold: assert property (
      cmd_valid_o && !cmd_done_i |=> cmd_valid_o && $stable(cmd_code_o) && $stable(cmd_data_o))
      else $error("command changed before done");
   chk_valid_ends: assert property (done |=> !cmd_valid_o)
      else $error("command still valid after done");
   chk_needs_break: assert property ($rose(cmd_valid_o) |-> $past(cpu_break_o))
      else $error("command issued outside break");
   chk_code_listed: assert property (
      cmd_valid_o |-> cmd_code_o inside {[8'h00:8'h0B], [8'h80:8'h87], 8'h8B})
      else $error("unlisted command code issued");
   chk_short_data: assert property (
      cmd_valid_o && cmd_code_o == 8'h8B |-> cmd_data_o[23:8] == 16'h0000)
      else $error("memory write data not low byte only");
   chk_rd_loads: assert property (
      done && cmd_code_o < 8'h08 |=> {rd_upper_o, rd_high_o, rd_low_o} == $past(rd_value_i))
      else $error("read bytes not loaded");
   chk_mem_read: assert property (
      done && cmd_code_o == 8'h0B |=> rd_low_o == $past(rv_low) && $stable(rd_upper_o))
      else $error("memory read byte wrong");
   chk_rd_stable: assert property (
      !done |=> $stable({rd_upper_o, rd_high_o, rd_low_o}))
      else $error("read bytes changed without read");
   chk_reset_hold: assert property (dev_reset_o && !reset_done_i |=> dev_reset_o)
      else $error("device reset dropped early");
   chk_reset_clear: assert property (dev_reset_o && reset_done_i |=> !dev_reset_o)
      else $error("device reset not cleared");
   chk_wake_pulse: assert property (wake_o |=> !wake_o)
      else $error("wake longer than one cycle");
   cov_cmd: cover property (done);
   cov_break: cover property ($rose(cpu_break_o));
   cov_reset: cover property ($rose(dev_reset_o));
endmodule // dra_props
bind dra_top dra_props u_props (.clk_i, .rstn_i, .cmd_done_i, .rd_value_i, .reset_done_i,
   .cmd_valid_o, .cmd_code_o, .cmd_data_o, .cpu_break_o, .dev_reset_o, .wake_o,
   .rd_upper_o, .rd_high_o, .rd_low_o);
`default_nettype wire

// ### verif/dra_host.sv
// debug host model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module dra_host (
   // link pins
   output var logic dbg_clk_o,
   output var logic dbg_data_o
);
   initial begin
      dbg_clk_o = 1'b1;
      dbg_data_o = 1'b1;
   end
   task automatic bit_out(input logic b);
      dbg_data_o <= b;
      #40 dbg_clk_o <= 1'b1;
      #80 dbg_clk_o <= 1'b0;
      #40;
   endtask
   // one frame, bytes to consecutive addresses, direction bit rd
   task automatic send(input logic [6:0] a, input logic [7:0] q[$], input logic rd = 1'b0);
      int i;
      int j;
      dbg_data_o <= 1'b0;
      #80 dbg_clk_o <= 1'b0;
      #80;
      for (i = 6; i >= 0; i--) bit_out(a[i]);
      bit_out(rd);
      for (j = 0; j < q.size(); j++) begin
         bit_out(1'b1);
         for (i = 7; i >= 0; i--) bit_out(q[j][i]);
      end
      dbg_data_o <= 1'b0;
      #40 dbg_clk_o <= 1'b1;
      #80 dbg_data_o <= 1'b1;
      #80;
   endtask
endmodule // dra_host
`default_nettype wire

// ### verif/dra_top_tb_top.sv
// testbench for the debug register access block
`timescale 1ns/1ps
`default_nettype none
module dra_top_tb_top;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic fetch_i = 1'b0;
   logic instr_end_i = 1'b0;
   logic cmd_done_i = 1'b0;
   logic reset_done_i = 1'b0;
   logic [23:0] instr_addr_i = 24'h000000;
   logic [23:0] rd_value_i = 24'h000000;
   logic [23:0] cmd_data_o, last_data, erd;
   logic [7:0] cmd_code_o, rd_upper_o, rd_high_o, rd_low_o, last_code;
   logic cmd_valid_o, cpu_break_o, dev_reset_o, wake_o;
   wire logic dbg_clk, dbg_data;
   logic [7:0] rsv [4] = '{8'h88, 8'h89, 8'h8A, 8'hFF};
   int fails = 0, n_tests = 0, ncmd = 0, nwake = 0, nrst = 0, dly = 0, i, w;
   always #10 clk_i = ~clk_i;
   dra_host host (.dbg_clk_o(dbg_clk), .dbg_data_o(dbg_data));
   dra_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .dbg_clk_i(dbg_clk), .dbg_data_i(dbg_data),
      .instr_addr_i(instr_addr_i), .fetch_i(fetch_i), .instr_end_i(instr_end_i),
      .cmd_done_i(cmd_done_i), .rd_value_i(rd_value_i), .cmd_valid_o(cmd_valid_o),
      .cmd_code_o(cmd_code_o), .cmd_data_o(cmd_data_o), .cpu_break_o(cpu_break_o),
      .dev_reset_o(dev_reset_o), .reset_done_i(reset_done_i), .wake_o(wake_o),
      .rd_upper_o(rd_upper_o), .rd_high_o(rd_high_o), .rd_low_o(rd_low_o));
   ////////////////////////////////////////////////////////////////////////////////
   // cpu core stand-in
   always @(posedge clk_i) begin
      cmd_done_i <= 1'b0;
      reset_done_i <= dev_reset_o && !reset_done_i;
      if (dev_reset_o && reset_done_i) nrst <= nrst + 1;
      if (wake_o) nwake <= nwake + 1;
      if (cmd_valid_o && !cmd_done_i) begin
         dly <= dly + 1;
         if (dly == 2) begin
            dly <= 0;
            cmd_done_i <= 1'b1;
            ncmd <= ncmd + 1;
            last_code <= cmd_code_o;
            last_data <= cmd_data_o;
            rd_value_i <= {cmd_code_o, 8'hC3, ~cmd_code_o};
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] q[$]);
      host.send(a, q);
      cyc(4);
   endtask
   // bytes end at the command register, last one is the code
   task automatic run_cmd(input logic [7:0] q[$], input logic go);
      int n0;
      int k;
      logic [7:0] c;
      n0 = ncmd;
      c = q[q.size() - 1];
      wr(7'(23 - q.size()), q);
      for (k = 0; k < 60 && ncmd == n0; k++) cyc(1);
      cyc(2);
      chk("cmd issued", 32'(go), 32'(ncmd != n0));
      if (go && ncmd == n0) give_verdict;
      if (go) chk("cmd code", 32'(c), 32'(last_code));
      if (go && c < 8'h08) erd = {c, 8'hC3, ~c};
      if (go && c == 8'h0B) erd[7:0] = ~c;
      chk("read bytes", 32'(erd), 32'({rd_upper_o, rd_high_o, rd_low_o}));
   endtask
   task automatic brk(input logic [7:0] ctl, input logic [23:0] a, input logic e);
      wr(7'h10, {ctl});
      instr_addr_i <= a;
      fetch_i <= 1'b1;
      @(posedge clk_i) fetch_i <= 1'b0;
      cyc(3);
      chk("break mid instr", 32'h0, 32'(cpu_break_o));
      instr_end_i <= 1'b1;
      @(posedge clk_i) instr_end_i <= 1'b0;
      cyc(3);
      chk("break", 32'(e), 32'(cpu_break_o));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      cyc(8);
      rstn_i <= 1'b1;
      cyc(4);
      chk("reset outputs", 32'h0, 32'({cpu_break_o, dev_reset_o, cmd_valid_o, wake_o}));
      erd = 24'h000000;
      run_cmd({8'h12, 8'h34, 8'h56, 8'h87}, 1'b0);
      wr(7'h10, {8'h80});
      chk("forced break", 32'h1, 32'(cpu_break_o));
      run_cmd({8'h12, 8'h34, 8'h56, 8'h87}, 1'b1);
      chk("write data", 32'h123456, 32'(last_data));
      for (i = 0; i < 12; i++) run_cmd({8'(i)}, 1'b1);
      run_cmd({8'h0A}, 1'b1);
      run_cmd({8'h00}, 1'b1);
      for (i = 8'h80; i < 8'h88; i++) run_cmd({8'(i)}, 1'b1);
      run_cmd({8'hAA, 8'hBB, 8'hCC, 8'h8B}, 1'b1);
      chk("short write", 32'h0000CC, 32'(last_data));
      for (i = 0; i < 4; i++) run_cmd({rsv[i]}, 1'b0);
      $display("test commands done");
      wr(7'h00, {8'h78, 8'h56, 8'h34, 8'h00, 8'hEF, 8'hCD, 8'hAB});
      brk(8'h10, 24'hABCDEE, 1'b0);
      brk(8'h10, 24'hABCDEF, 1'b1);
      brk(8'h14, 24'hABCD00, 1'b1);
      brk(8'h14, 24'hABCE00, 1'b0);
      brk(8'h08, 24'h345679, 1'b0);
      brk(8'h08, 24'h345678, 1'b1);
      brk(8'h0A, 24'h3456FF, 1'b1);
      brk(8'h02, 24'h3456FF, 1'b0);
      brk(8'h01, 24'h000100, 1'b1);
      brk(8'h00, 24'h000100, 1'b0);
      host.send(7'h10, {8'h80}, 1'b1);
      cyc(4);
      chk("read frame ignored", 32'h0, 32'(cpu_break_o));
      $display("test breaks done");
      w = nwake;
      wr(7'h11, {8'h80});
      chk("reset events", 32'h1, 32'(nrst));
      chk("reset cleared", 32'h0, 32'(dev_reset_o));
      chk("wake pulses", 32'h1, 32'(nwake - w));
      wr(7'h11, {8'h00});
      chk("reset events", 32'h1, 32'(nrst));
      chk("wake pulses", 32'h2, 32'(nwake - w));
      $display("test master done");
      give_verdict;
   end
   initial begin
      cyc(100000);
      fails++;
      give_verdict;
   end
endmodule // dra_top_tb_top
`default_nettype wire
